// ---- hdl/uart_line_format_control.sv ----
// UART channel with line format control behind an AXI4-Lite slave
//
// The AXI4-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ns
module uart_line_format_control #(
  parameter int DIV_W = 16
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Serial line
  output logic             txd,
  input  wire logic        rxd,
  // Interrupt
  output logic             irq
);
  import lfc_pkg::*;

  // Refuse divisor widths the register map cannot hold
  if (DIV_W < 2 || DIV_W > 16) begin : g_bad_div_w
    $error("uart_line_format_control: DIV_W out of range");
  end

  logic [7:0]       line_format_control_r;
  logic [DIV_W-1:0] div_r;
  logic [EV_N-1:0]  stat_r, mask_r, ev_set;
  logic [7:0]       rx_data_r;
  logic             wr_go, rd_go, stat_rd;
  logic             tick;
  logic             dlab, brk, pforce, peven, pen, stop2;
  logic [3:0]       len;
  ser_state_t       tx_st;

  // Decoded line format fields
  assign dlab   = line_format_control_r[B_DLAB];
  assign brk    = line_format_control_r[B_BRK];
  assign pforce = line_format_control_r[B_FORCE];
  assign peven  = line_format_control_r[B_EVEN];
  assign pen    = line_format_control_r[B_PEN];
  assign stop2  = line_format_control_r[B_STOP];
  assign len    = LEN_MIN + {2'b00, line_format_control_r[B_LEN_H:0]};

  // Parity bit for a character, odd, even or forced
  function automatic logic par_of(input logic [7:0] d, input logic [3:0] n);
    logic [7:0] m;
    m = d & (8'hFF >> (4'h8 - n));
    if (pforce) par_of = ~peven;
    else        par_of = (^m) ^ ~peven;
  endfunction

  // Stop length in ticks
  function automatic logic [5:0] stop_ticks();
    if (!stop2)              stop_ticks = TK_BIT;
    else if (len == LEN_MIN) stop_ticks = TK_ST1P5;
    else                     stop_ticks = TK_ST2;
  endfunction

  baud_tick #(.DIV_W(DIV_W)) u_tick (
    .ref_clk (ref_clk),
    .rst     (rst),
    .divisor (div_r),
    .tick    (tick)
  );

  // Bus slave handshakes and decode
  logic wr_hit, rd_hit;
  assign wr_go = s_axi_awready & s_axi_awvalid & s_axi_wvalid;
  assign rd_go = s_axi_arready & s_axi_arvalid;

  // Write channels taken together once both are offered
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready  <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Write address decode, divisor only while latch is open
  always_comb begin
    case (s_axi_awaddr)
      OFF_LFC, OFF_TXD, OFF_MASK: wr_hit = 1'b1;
      OFF_DIV:                    wr_hit = dlab;
      default:                    wr_hit = 1'b0;
    endcase
  end

  // Line format register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      line_format_control_r <= LFC_RST;
    end else if (wr_go && s_axi_awaddr == OFF_LFC && s_axi_wstrb[0]) begin
      line_format_control_r <= s_axi_wdata[7:0];
    end
  end

  // Divisor latch, reachable only with the access bit set
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_r <= DIV_W'(DIV_RST);
    end else if (wr_go && s_axi_awaddr == OFF_DIV && dlab) begin
      for (int i = 0; i < DIV_W; i++) begin
        if (s_axi_wstrb[i/8]) div_r[i] <= s_axi_wdata[i];
      end
    end
  end

  // Interrupt mask
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mask_r <= MASK_RST;
    end else if (wr_go && s_axi_awaddr == OFF_MASK && s_axi_wstrb[0]) begin
      mask_r <= s_axi_wdata[EV_N-1:0];
    end
  end

  // Read data mux
  logic [31:0] rd_val;
  always_comb begin
    rd_val = '0;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      OFF_LFC:  rd_val[7:0] = line_format_control_r;
      OFF_DIV: begin
        rd_hit = dlab;
        if (dlab) rd_val[DIV_W-1:0] = div_r;
      end
      OFF_RXD:  rd_val[7:0] = rx_data_r;
      OFF_STAT: rd_val[EV_N-1:0] = stat_r;
      OFF_MASK: rd_val[EV_N-1:0] = mask_r;
      OFF_BUSY: rd_val[0] = tx_st != S_IDLE;
      default:  rd_hit = 1'b0;
    endcase
  end

  assign stat_rd = rd_go && s_axi_araddr == OFF_STAT;

  // Read channel, one beat at a time
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Sticky status, set wins over clear on read
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stat_r <= '0;
      irq    <= 1'b0;
    end else begin
      stat_r <= (stat_rd ? '0 : stat_r) | ev_set;
      irq    <= |(((stat_rd ? '0 : stat_r) | ev_set) & mask_r);
    end
  end

  // Transmitter state
  logic [7:0] tx_sh_r;
  logic [5:0] tx_tk_r;
  logic [3:0] tx_bit_r;
  logic       tx_line_r, tx_done;

  // Transmit sequencer on the 16x tick
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_st     <= S_IDLE;
      tx_sh_r   <= '0;
      tx_tk_r   <= '0;
      tx_bit_r  <= '0;
      tx_line_r <= 1'b1;
      tx_done   <= 1'b0;
    end else begin
      tx_done <= 1'b0;
      case (tx_st)
        S_IDLE: begin
          tx_line_r <= 1'b1;
          if (wr_go && s_axi_awaddr == OFF_TXD && s_axi_wstrb[0]) begin
            tx_sh_r   <= s_axi_wdata[7:0];
            tx_st     <= S_START;
            tx_tk_r   <= TK_BIT;
            tx_line_r <= 1'b0;
          end
        end
        S_START: if (tick) begin
          tx_tk_r <= tx_tk_r - 6'h01;
          if (tx_tk_r == 6'h01) begin
            tx_st     <= S_DATA;
            tx_tk_r   <= TK_BIT;
            tx_bit_r  <= 4'h1;
            tx_line_r <= tx_sh_r[0];
          end
        end
        S_DATA: if (tick) begin
          tx_tk_r <= tx_tk_r - 6'h01;
          if (tx_tk_r == 6'h01) begin
            tx_tk_r <= TK_BIT;
            if (tx_bit_r == len) begin
              tx_st     <= pen ? S_PAR : S_STOP;
              tx_line_r <= pen ? par_of(tx_sh_r, len) : 1'b1;
              if (!pen) tx_tk_r <= stop_ticks();
            end else begin
              tx_line_r <= tx_sh_r[tx_bit_r[2:0]];
              tx_bit_r  <= tx_bit_r + 4'h1;
            end
          end
        end
        S_PAR: if (tick) begin
          tx_tk_r <= tx_tk_r - 6'h01;
          if (tx_tk_r == 6'h01) begin
            tx_st     <= S_STOP;
            tx_tk_r   <= stop_ticks();
            tx_line_r <= 1'b1;
          end
        end
        S_STOP: if (tick) begin
          tx_tk_r <= tx_tk_r - 6'h01;
          if (tx_tk_r == 6'h01) begin
            tx_st   <= S_IDLE;
            tx_done <= 1'b1;
          end
        end
        default: tx_st <= S_IDLE;
      endcase
    end
  end

  // Line output, break overrides the sequencer
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) txd <= 1'b1;
    else     txd <= brk ? 1'b0 : tx_line_r;
  end

  // Receiver state
  ser_state_t rx_st;
  logic [7:0] rx_sh_r;
  logic [5:0] rx_tk_r;
  logic [3:0] rx_bit_r;
  logic       rx_rdy, rx_perr, rx_ferr, rx_par_r;

  // Receive sequencer, samples at bit centres
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_st     <= S_IDLE;
      rx_sh_r   <= '0;
      rx_tk_r   <= '0;
      rx_bit_r  <= '0;
      rx_par_r  <= 1'b0;
      rx_data_r <= '0;
      rx_rdy    <= 1'b0;
      rx_perr   <= 1'b0;
      rx_ferr   <= 1'b0;
    end else begin
      rx_rdy  <= 1'b0;
      rx_perr <= 1'b0;
      rx_ferr <= 1'b0;
      if (tick) begin
        rx_tk_r <= rx_tk_r - 6'h01;
        case (rx_st)
          S_IDLE: if (!rxd) begin
            rx_st   <= S_START;
            rx_tk_r <= TK_HALF;
          end
          S_START: if (rx_tk_r == 6'h01) begin
            rx_st    <= rxd ? S_IDLE : S_DATA; // Glitch rejected
            rx_tk_r  <= TK_BIT;
            rx_bit_r <= 4'h0;
            rx_sh_r  <= '0;
          end
          S_DATA: if (rx_tk_r == 6'h01) begin
            rx_tk_r  <= TK_BIT;
            rx_sh_r[rx_bit_r[2:0]] <= rxd;
            rx_bit_r <= rx_bit_r + 4'h1;
            if (rx_bit_r + 4'h1 == len) rx_st <= pen ? S_PAR : S_STOP;
          end
          S_PAR: if (rx_tk_r == 6'h01) begin
            rx_tk_r  <= TK_BIT;
            rx_par_r <= rxd;
            rx_st    <= S_STOP;
          end
          S_STOP: if (rx_tk_r == 6'h01) begin
            rx_st     <= S_IDLE;
            rx_data_r <= rx_sh_r;
            rx_rdy    <= 1'b1;
            rx_ferr   <= ~rxd;
            rx_perr   <= pen && (rx_par_r != par_of(rx_sh_r, len));
          end
          default: rx_st <= S_IDLE;
        endcase
      end
    end
  end

  // Event collection for the status register
  always_comb begin
    ev_set            = '0;
    ev_set[EV_RXRDY]  = rx_rdy;
    ev_set[EV_TXDONE] = tx_done;
    ev_set[EV_PERR]   = rx_perr;
    ev_set[EV_FERR]   = rx_ferr;
  end
endmodule

// ---- hdl/lfc_pkg.sv ----
// Constants shared by the line format control block
package lfc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_LFC    = 8'h00;
  localparam logic [7:0] OFF_DIV    = 8'h04;
  localparam logic [7:0] OFF_TXD    = 8'h08;
  localparam logic [7:0] OFF_RXD    = 8'h0C;
  localparam logic [7:0] OFF_STAT   = 8'h10;
  localparam logic [7:0] OFF_MASK   = 8'h14;
  localparam logic [7:0] OFF_BUSY   = 8'h18;
  // Line format field positions
  localparam int B_DLAB  = 7;
  localparam int B_BRK   = 6;
  localparam int B_FORCE = 5;
  localparam int B_EVEN  = 4;
  localparam int B_PEN   = 3;
  localparam int B_STOP  = 2;
  localparam int B_LEN_H = 1;
  // Reset values
  localparam logic [7:0]  LFC_RST  = 8'h00;
  localparam logic [15:0] DIV_RST  = 16'h0001;
  localparam logic [3:0]  MASK_RST = 4'h0;
  // Event bits in status and mask
  localparam int EV_RXRDY = 0;
  localparam int EV_TXDONE = 1;
  localparam int EV_PERR = 2;
  localparam int EV_FERR = 3;
  localparam int EV_N = 4;
  // Oversampling timing, in 16x ticks
  localparam logic [5:0] TK_BIT   = 6'h10;
  localparam logic [5:0] TK_HALF  = 6'h08;
  localparam logic [5:0] TK_ST1P5 = 6'h18;
  localparam logic [5:0] TK_ST2   = 6'h20;
  localparam logic [3:0] LEN_MIN  = 4'h5;
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Serial engine states
  typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_PAR, S_STOP} ser_state_t;
endpackage

// ---- hdl/baud_tick.sv ----
// Divider making the one-cycle 16x oversampling tick
`timescale 1ns/1ns
module baud_tick #(
  parameter int DIV_W = 16
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // Divisor and tick
  input  wire logic [DIV_W-1:0] divisor,
  output logic                  tick
);
  logic [DIV_W-1:0] cnt_r;

  // Refuse a divider too narrow to count
  if (DIV_W < 2) begin : g_bad_div_w
    $error("baud_tick: DIV_W too small");
  end

  // Count down from divisor, a zero divisor acts as one
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else if (cnt_r <= DIV_W'(1)) begin
      cnt_r <= divisor;
      tick  <= 1'b1;
    end else begin
      cnt_r <= cnt_r - DIV_W'(1);
      tick  <= 1'b0;
    end
  end
endmodule

// ---- tb/lfc_properties.sv ----
// Port checks for the line format control channel
`timescale 1ns/1ns
module lfc_properties
  import lfc_pkg::*;
(
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst,
  // Bus signals watched
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Line and interrupt
  input wire logic        txd,
  input wire logic        irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [7:0] lf_r;
  // Shadow of the line format register, taken at the write handshake
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lf_r <= LFC_RST;
    end else if (s_axi_awready && s_axi_awaddr == OFF_LFC) begin
      lf_r <= s_axi_wdata[7:0];
    end
  end
  pair_ready_a: assert property (s_axi_awready |-> s_axi_wready)
    else $error("write ready halves apart");
  ready_pulse_a: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("read ready over one cycle");
  wr_answer_a: assert property (s_axi_awready |=> s_axi_bvalid)
    else $error("write response late");
  rd_answer_a: assert property (s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  div_closed_a: assert property (
    s_axi_arready && s_axi_araddr == OFF_DIV && !lf_r[B_DLAB] |=> s_axi_rresp == RESP_SLVERR)
    else $error("closed divisor read accepted");
  div_open_a: assert property (
    s_axi_arready && s_axi_araddr == OFF_DIV && lf_r[B_DLAB] |=> s_axi_rresp == RESP_OKAY)
    else $error("open divisor read refused");
  break_low_a: assert property (lf_r[B_BRK] |=> !txd)
    else $error("line not low in break");
  reset_idle_a: assert property ($fell(rst) |-> txd && !irq)
    else $error("line not idle after reset");
  cover property (s_axi_arready && s_axi_araddr == OFF_DIV && lf_r[B_DLAB]);
  cover property (lf_r[B_BRK] && !txd);
  cover property ($rose(irq));
endmodule

bind uart_line_format_control lfc_properties u_lfc_properties (
  .ref_clk, .rst, .s_axi_awaddr, .s_axi_wdata, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
  .s_axi_araddr, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .txd, .irq);

// ---- tb/remote_station.sv ----
// Remote serial station: sends on rxd, decodes txd
`timescale 1ns/1ns
module remote_station #(
  parameter int BIT = 16
) (
  // Clock and format in use
  input  wire logic       ref_clk,
  input  wire logic [7:0] fmt,
  // Serial line
  input  wire logic       txd,
  output logic            rxd
);
  // Line rests at mark
  initial rxd = 1'b1;
  // Parity bit for the current format
  function automatic logic par_of(input logic [7:0] d);
    logic [7:0] m;
    m = d & (8'hFF >> (3 - fmt[1:0]));
    if (fmt[5]) return !fmt[4];
    return fmt[4] ? ^m : ~^m;
  endfunction
  // One bit time on the line
  task automatic drive(input logic b);
    @(posedge ref_clk);
    rxd <= b;
    repeat (BIT - 1) @(posedge ref_clk);
  endtask
  // Whole character; flip[0] spoils parity, flip[1] the stop bit
  task automatic send(input logic [7:0] d, input logic [1:0] flip);
    drive(1'b0);
    for (int i = 0; i < 5 + int'(fmt[1:0]); i++) drive(d[i]);
    if (fmt[3]) drive(par_of(d) ^ flip[0]);
    drive(~flip[1]);
    if (flip[1]) drive(1'b1);
  endtask
  // Decode one character; nxt is the bit after the data
  task automatic take(output logic [7:0] d, output logic nxt);
    d = 8'h00;
    @(negedge txd);
    repeat (BIT / 2) @(posedge ref_clk);
    for (int i = 0; i < 5 + int'(fmt[1:0]); i++) begin
      repeat (BIT) @(posedge ref_clk);
      d[i] = txd;
    end
    repeat (BIT) @(posedge ref_clk);
    nxt = txd;
  endtask
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the line format control channel
`timescale 1ns/1ns
module tb_top;
  import lfc_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        txd, rxd, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [7:0]  fmt = 8'h00;
  int          num_errors = 0;
  int          check_count = 0;

  // Clock
  always #5 ref_clk = ~ref_clk;

  uart_line_format_control u_uart_line_format_control (
    .ref_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .txd, .rxd, .irq);
  remote_station u_remote_station (.ref_clk, .fmt, .txd, .rxd);

  task automatic chk(input logic [31:0] e, input logic [31:0] g, input string n);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // Bus write, response compared
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge ref_clk); while (!(s_axi_awready && s_axi_wready));
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge ref_clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(32'(er), 32'(s_axi_bresp), "write resp");
  endtask
  // Bus read, data and response compared
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge ref_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(ed, s_axi_rdata, "read data");
    chk(32'(er), 32'(s_axi_rresp), "read resp");
  endtask
  task automatic set_fmt(input logic [7:0] f);
    wr(OFF_LFC, 32'(f), RESP_OKAY);
    fmt = f;
  endtask
  // Reset values, divisor gate, unmapped place
  task automatic t_regs;
    rd(OFF_LFC, 32'h0, RESP_OKAY);
    rd(OFF_DIV, 32'h0, RESP_SLVERR);
    set_fmt(8'h80);
    wr(OFF_DIV, 32'h1, RESP_OKAY);
    rd(OFF_DIV, 32'h1, RESP_OKAY);
    set_fmt(8'h00);
    wr(OFF_DIV, 32'h3, RESP_SLVERR);
    set_fmt(8'h80);
    rd(OFF_DIV, 32'h1, RESP_OKAY);
    set_fmt(8'h00);
    rd(8'h1C, 32'h0, RESP_SLVERR);
  endtask
  // Every length and parity mode on transmit
  task automatic t_tx;
    logic [7:0] fl[6] = '{8'h03, 8'h0B, 8'h1A, 8'h29, 8'h38, 8'h30};
    logic [7:0] d, v;
    logic       p;
    foreach (fl[i]) begin
      v = 8'hC5 ^ 8'(i);
      set_fmt(fl[i]);
      fork
        wr(OFF_TXD, 32'(v), RESP_OKAY);
        u_remote_station.take(d, p);
      join
      chk(32'(v & (8'hFF >> (3 - fl[i][1:0]))), 32'(d), "tx data");
      chk(32'(fl[i][3] ? u_remote_station.par_of(v) : 1'b1), 32'(p), "tx parity");
      repeat (40) @(posedge ref_clk);
    end
  endtask
  // Stop lengths timed by the done interrupt, then masking
  task automatic t_stop;
    int         t[4];
    logic [7:0] fl[4] = '{8'h03, 8'h07, 8'h00, 8'h04};
    rd(OFF_STAT, 32'h2, RESP_OKAY);
    wr(OFF_MASK, 32'h2, RESP_OKAY);
    rd(OFF_MASK, 32'h2, RESP_OKAY);
    foreach (fl[i]) begin
      set_fmt(fl[i]);
      fork
        wr(OFF_TXD, 32'h55, RESP_OKAY);
        begin
          @(negedge txd);
          t[i] = int'($time / 10);
          @(posedge irq);
          t[i] = int'($time / 10) - t[i];
        end
      join
      rd(OFF_STAT, 32'h2, RESP_OKAY);
      repeat (2) @(posedge ref_clk);
      chk(32'h0, 32'(irq), "irq after clear");
    end
    chk(32'd16, 32'(t[1] - t[0]), "two stop extra");
    chk(32'd8, 32'(t[3] - t[2]), "one and half stop extra");
    wr(OFF_MASK, 32'h0, RESP_OKAY);
    wr(OFF_TXD, 32'h0F, RESP_OKAY);
    repeat (200) @(posedge ref_clk);
    chk(32'h0, 32'(irq), "masked irq");
    rd(OFF_STAT, 32'h2, RESP_OKAY);
  endtask
  // Receive with good and bad parity, forced, bad stop, parity off
  task automatic t_rx;
    set_fmt(8'h1B);
    u_remote_station.send(8'h3C, 2'b00);
    rd(OFF_STAT, 32'h1, RESP_OKAY);
    rd(OFF_RXD, 32'h3C, RESP_OKAY);
    u_remote_station.send(8'h3C, 2'b01);
    rd(OFF_STAT, 32'h5, RESP_OKAY);
    set_fmt(8'h29);
    u_remote_station.send(8'h2A, 2'b00);
    rd(OFF_STAT, 32'h1, RESP_OKAY);
    rd(OFF_RXD, 32'h2A, RESP_OKAY);
    u_remote_station.send(8'h2A, 2'b01);
    rd(OFF_STAT, 32'h5, RESP_OKAY);
    u_remote_station.send(8'h15, 2'b10);
    rd(OFF_STAT, 32'h9, RESP_OKAY);
    set_fmt(8'h30);
    u_remote_station.send(8'h15, 2'b01);
    rd(OFF_STAT, 32'h1, RESP_OKAY);
    rd(OFF_RXD, 32'h15, RESP_OKAY);
  endtask
  // Break holds the line low, even over a character
  task automatic t_brk;
    set_fmt(8'h43);
    repeat (30) @(posedge ref_clk);
    chk(32'h0, 32'(txd), "break line");
    wr(OFF_TXD, 32'hFF, RESP_OKAY);
    rd(OFF_BUSY, 32'h1, RESP_OKAY);
    repeat (30) @(posedge ref_clk);
    chk(32'h0, 32'(txd), "break over char");
    set_fmt(8'h03);
    repeat (200) @(posedge ref_clk);
    chk(32'h1, 32'(txd), "line after break");
    rd(OFF_BUSY, 32'h0, RESP_OKAY);
  endtask
  task automatic conclude;
    if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs;
    t_tx;
    t_stop;
    t_rx;
    t_brk;
    conclude;
  end
  // Watchdog
  initial begin
    #500000;
    num_errors++;
    conclude;
  end
endmodule
